// ==== logic/clm_avg.sv ====
// eight-sample averager for the measured output voltage
`timescale 1ns/100ps
`default_nettype none
module clm_avg #(
    parameter int unsigned W = 12,
    parameter int unsigned SAMPLE_CYC = clm_pkg::SAMPLE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [W-1:0] sample,
    output logic [W-1:0] avg,
    output logic done
);
    localparam int unsigned CW = $clog2(SAMPLE_CYC);
    logic [CW-1:0] tick;
    logic [2:0] cnt;
    logic [W+2:0] acc;

    // sample pacing: eight samples spread over the window
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick <= '0;
        end else if (!run || tick == CW'(SAMPLE_CYC - 1)) begin
            tick <= '0;
        end else begin
            tick <= tick + 1'b1;
        end
    end

    // accumulate, then publish the mean with a one-cycle done
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= '0;
            acc <= '0;
            avg <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!run) begin
                cnt <= '0;
                acc <= '0;
            end else if (tick == CW'(SAMPLE_CYC - 1)) begin
                cnt <= cnt + 1'b1;
                if (cnt == 3'h7) begin
                    avg <= W'((acc + (W+3)'(sample)) >> 3);
                    acc <= '0;
                    done <= 1'b1;
                end else begin
                    acc <= acc + (W+3)'(sample);
                end
            end
        end
    end
endmodule : clm_avg
`default_nettype wire

// ==== logic/clm_margin_pwm.sv ====
// closed-loop margin pwm controller for one supply channel
// ---------------------------------------------------------------
// Overview of operation
// - the pwm output repeats at 62.5 kHz.
// - duty is a 6-bit value and each adjustment is one lsb.
// - margining runs only while the operation command picks high or low.
// - margining waits until all enabled supplies are above power-good-on.
// - on start the pwm is enabled and loaded with the seed field.
// - eight samples are averaged over 40 ms; duty moves only after that.
// - if the average misses the target by more than 1% duty moves one step.
// - the slope bit picks which duty direction raises the voltage.
// - duty at 0% or 100% with target unmet is a margin fault; keep going.
// - a fault sets status byte nota, word nota and mfr, and margin fault.
// - a fault asserts alert only when alert is enabled in the mode config.
// - first average after seeding past the target is a margin fault.
// - bits 14:6 of the setup word always read zero.
// - bits 5:0 hold the seed used for both margin directions.
// - status flags latch; alert rises only on a newly set flag.
// ---------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module clm_margin_pwm #(
    parameter int unsigned VW = 12,
    parameter int unsigned SAMPLE_CYC = clm_pkg::SAMPLE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire clm_pkg::clm_wreq_t wreq,
    input wire logic [7:0] rd_addr,
    input wire logic clear_faults,
    input wire logic [7:0] operation,
    input wire logic all_power_good,
    input wire logic alert_enable,
    input wire logic [VW-1:0] vout_sample,
    input wire logic [VW-1:0] margin_high_target,
    input wire logic [VW-1:0] margin_low_target,
    output logic [15:0] rd_data,
    output clm_pkg::clm_status_t status,
    output logic pwm_out,
    output logic pwm_enable,
    output logic [5:0] duty,
    output logic alert_n
);
    localparam int unsigned PCW = $clog2(clm_pkg::PWM_PERIOD_CYC);
    localparam logic [PCW-1:0] PWM_LAST =
        PCW'(clm_pkg::PWM_PERIOD_CYC - 1);
    // duty 63 means 100%: the pulse covers a full period
    localparam logic [5:0] DUTY_MAX = 6'h3f;

    clm_pkg::clm_state_t state;
    clm_pkg::clm_state_t next_state;
    logic [15:0] setup;
    logic [PCW-1:0] pcnt;
    logic [PCW-1:0] hi_cyc;
    logic margin_req;
    logic run;
    logic [VW-1:0] avg;
    logic avg_done;
    logic [VW-1:0] target;
    logic [VW+6:0] tol;
    logic below;
    logic above;
    logic want_up;
    logic at_rail;
    logic fault_ev;
    logic fault_flag;

    // ---------------------------------------------------------------
    // register access
    // ---------------------------------------------------------------
    // setup word: only slope and seed are stored, the rest reads zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            setup <= clm_pkg::SETUP_RESET;
        end else if (wreq.wr && wreq.addr == clm_pkg::MARGIN_SETUP_WORD_OFS)
        begin
            setup <= wreq.data & clm_pkg::SETUP_MASK;
        end
    end

    // registered read port
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= '0;
        end else begin
            unique case (rd_addr)
                clm_pkg::MARGIN_SETUP_WORD_OFS: rd_data <= setup;
                clm_pkg::STATUS_BYTE_OFS:
                    rd_data <= {8'h00, status.status_byte};
                clm_pkg::STATUS_WORD_OFS: rd_data <= status.status_word;
                clm_pkg::STATUS_MFR_OFS:
                    rd_data <= {8'h00, status.status_mfr};
                default: rd_data <= '0;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // control sequence
    // ---------------------------------------------------------------
    assign margin_req = operation[5:4] == clm_pkg::OP_MARGIN_LOW ||
                        operation[5:4] == clm_pkg::OP_MARGIN_HIGH;
    assign run = state != clm_pkg::CLM_IDLE;

    always_comb begin
        next_state = state;
        unique case (state)
            clm_pkg::CLM_IDLE:
                if (margin_req && all_power_good) begin
                    next_state = clm_pkg::CLM_SEED;
                end
            clm_pkg::CLM_SEED:
                if (!margin_req) begin
                    next_state = clm_pkg::CLM_IDLE;
                end else if (avg_done) begin
                    next_state = clm_pkg::CLM_TRACK;
                end
            clm_pkg::CLM_TRACK:
                if (!margin_req) begin
                    next_state = clm_pkg::CLM_IDLE;
                end
            default: next_state = clm_pkg::CLM_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= clm_pkg::CLM_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ---------------------------------------------------------------
    // averaging and comparison
    // ---------------------------------------------------------------
    clm_avg #(
        .W(VW),
        .SAMPLE_CYC(SAMPLE_CYC)
    ) u_avg (
        .clk(clk),
        .rst(rst),
        .run(run),
        .sample(vout_sample),
        .avg(avg),
        .done(avg_done)
    );

    // tolerance of 1% done as 100*|diff| > target, no divider needed
    assign target = (operation[5:4] == clm_pkg::OP_MARGIN_HIGH) ?
                    margin_high_target : margin_low_target;
    assign tol = (VW+7)'(target) * (VW+7)'(clm_pkg::TOL_PCT);
    assign below = (VW+7)'(target - avg) * (VW+7)'(100) > tol &&
                   avg < target;
    assign above = (VW+7)'(avg - target) * (VW+7)'(100) > tol &&
                   avg > target;
    // raise duty when it moves voltage the way we need
    assign want_up = setup[clm_pkg::SLOPE_BIT] ? below : above;
    assign at_rail = want_up ? (duty == DUTY_MAX) : (duty == 6'h00);

    // duty register: seed on start, one step per window
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            duty <= '0;
            pwm_enable <= 1'b0;
        end else if (state == clm_pkg::CLM_IDLE) begin
            pwm_enable <= 1'b0;
            if (next_state == clm_pkg::CLM_SEED) begin
                duty <= setup[clm_pkg::SEED_MSB:0];
                pwm_enable <= 1'b1;
            end
        end else if (!margin_req) begin
            pwm_enable <= 1'b0;
        end else if (avg_done && (below || above) && !at_rail) begin
            duty <= want_up ? duty + 1'b1 : duty - 1'b1;
        end
    end

    // fault: rail hit with target unmet, or seed overshoot
    assign fault_ev = margin_req && avg_done && (below || above) &&
        (at_rail || (state == clm_pkg::CLM_SEED &&
         (operation[5:4] == clm_pkg::OP_MARGIN_LOW ? below : above)));

    // ---------------------------------------------------------------
    // pwm generator
    // ---------------------------------------------------------------
    assign hi_cyc = PCW'((32'(duty) * clm_pkg::PWM_PERIOD_CYC) /
                         32'(DUTY_MAX));

    // period counter at 62.5 kHz
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pcnt <= '0;
        end else if (!pwm_enable || pcnt == PWM_LAST) begin
            pcnt <= '0;
        end else begin
            pcnt <= pcnt + 1'b1;
        end
    end

    // pulse output, low whenever disabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= pwm_enable && (pcnt < hi_cyc ||
                       duty == DUTY_MAX);
        end
    end

    // ---------------------------------------------------------------
    // status and alert
    // ---------------------------------------------------------------
    // sticky flags; a new fault wins over a clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fault_flag <= 1'b0;
        end else if (fault_ev) begin
            fault_flag <= 1'b1;
        end else if (clear_faults) begin
            fault_flag <= 1'b0;
        end
    end

    always_comb begin
        status = '0;
        status.status_byte[clm_pkg::NOTA_BIT] = fault_flag;
        status.status_word[clm_pkg::NOTA_BIT] = fault_flag;
        status.status_word[clm_pkg::MFR_WORD_BIT] = fault_flag;
        status.status_mfr[clm_pkg::MARGIN_FAULT_BIT] = fault_flag;
    end

    // alert only on a newly set flag, held until flags are cleared; a
    // fault that meets a clear sets the flag again, so it counts as new
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alert_n <= 1'b1;
        end else if (fault_ev && alert_enable &&
                     (!fault_flag || clear_faults)) begin
            alert_n <= 1'b0;
        end else if (clear_faults) begin
            alert_n <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    property p_off_when_idle;
        @(posedge clk) disable iff (rst)
        !margin_req |=> !pwm_enable;
    endproperty
    a_off_when_idle: assert property (p_off_when_idle)
        else $error("pwm left enabled outside margin");

    property p_seed_load;
        @(posedge clk) disable iff (rst)
        (state == clm_pkg::CLM_IDLE && next_state == clm_pkg::CLM_SEED)
        |=> (duty == $past(setup[5:0]) && pwm_enable);
    endproperty
    a_seed_load: assert property (p_seed_load)
        else $error("seed not loaded on start");

    property p_no_start_wo_pg;
        @(posedge clk) disable iff (rst)
        (state == clm_pkg::CLM_IDLE && !all_power_good) |=>
        state == clm_pkg::CLM_IDLE;
    endproperty
    a_no_start_wo_pg: assert property (p_no_start_wo_pg)
        else $error("margin started before power good");

    property p_duty_only_after_avg;
        @(posedge clk) disable iff (rst)
        (run && margin_req && !avg_done) |=> $stable(duty);
    endproperty
    a_duty_only_after_avg: assert property (p_duty_only_after_avg)
        else $error("duty changed outside a window end");

    property p_one_step;
        @(posedge clk) disable iff (rst)
        (run && margin_req && avg_done && (below || above) && !at_rail)
        |=> (duty == $past(duty) + 6'h01 || duty == $past(duty) - 6'h01);
    endproperty
    a_one_step: assert property (p_one_step)
        else $error("duty did not move one step");

    property p_pwm_low_off;
        @(posedge clk) disable iff (rst)
        !pwm_enable |=> !pwm_out;
    endproperty
    a_pwm_low_off: assert property (p_pwm_low_off)
        else $error("pwm pulses while disabled");

    property p_fault_latch;
        @(posedge clk) disable iff (rst)
        fault_ev |=> (status.status_mfr[0] && status.status_word[12]
                      && status.status_byte[0]);
    endproperty
    a_fault_latch: assert property (p_fault_latch)
        else $error("fault flags not set");

    property p_alert_gate;
        @(posedge clk) disable iff (rst)
        (fault_ev && !alert_enable && alert_n) |=> alert_n;
    endproperty
    a_alert_gate: assert property (p_alert_gate)
        else $error("alert raised while disabled");

    property p_setup_zero;
        @(posedge clk) disable iff (rst)
        setup[14:6] == 9'h000;
    endproperty
    a_setup_zero: assert property (p_setup_zero)
        else $error("setup reserved bits nonzero");

    property p_period;
        @(posedge clk) disable iff (rst)
        (pwm_enable && pcnt == PWM_LAST) |=> (pcnt == '0);
    endproperty
    a_period: assert property (p_period)
        else $error("pwm period wrong");
endmodule : clm_margin_pwm
`default_nettype wire

// ==== pkg/clm_pkg.sv ====
// package: constants and types for the closed-loop margin pwm block
package clm_pkg;
    // ---------------------------------------------------------------
    // clock and timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned PWM_RATE_HZ = 62500;
    localparam int unsigned PWM_PERIOD_CYC = CLK_HZ / PWM_RATE_HZ;
    localparam int unsigned DUTY_STEPS = 64;
    localparam int unsigned AVG_WINDOW_MS = 40;
    localparam int unsigned AVG_SAMPLES = 8;
    localparam int unsigned SAMPLE_MS = AVG_WINDOW_MS / AVG_SAMPLES;
    localparam int unsigned SAMPLE_CYC = CLK_HZ / 1000 * SAMPLE_MS;
    localparam int unsigned TOL_PCT = 1;

    // ---------------------------------------------------------------
    // register map and fields
    // ---------------------------------------------------------------
    localparam logic [7:0] MARGIN_SETUP_WORD_OFS = 8'he0;
    localparam logic [7:0] STATUS_BYTE_OFS = 8'h78;
    localparam logic [7:0] STATUS_WORD_OFS = 8'h79;
    localparam logic [7:0] STATUS_MFR_OFS = 8'h80;
    localparam int unsigned SLOPE_BIT = 15;
    localparam int unsigned SEED_MSB = 5;
    localparam logic [15:0] SETUP_MASK = 16'h803f;
    localparam logic [15:0] SETUP_RESET = 16'h0000;
    localparam int unsigned NOTA_BIT = 0;
    localparam int unsigned MFR_WORD_BIT = 12;
    localparam int unsigned MARGIN_FAULT_BIT = 0;

    // operation command margin selections (bits 5:4 of the command byte)
    localparam logic [1:0] OP_MARGIN_LOW = 2'h1;
    localparam logic [1:0] OP_MARGIN_HIGH = 2'h2;

    typedef enum logic [1:0] {
        CLM_IDLE = 2'b00,
        CLM_SEED = 2'b01,
        CLM_TRACK = 2'b10
    } clm_state_t;

    // register write request
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [15:0] data;
    } clm_wreq_t;

    // status flags carried to the outside
    typedef struct packed {
        logic [7:0] status_byte;
        logic [15:0] status_word;
        logic [7:0] status_mfr;
    } clm_status_t;
endpackage : clm_pkg

// ==== verif/clm_supply_model.sv ====
// supply trim network model: filtered pwm turned into vout samples
`timescale 1ns/100ps
`default_nettype none
module clm_supply_model #(
    parameter int unsigned BASE = 1800,
    parameter int unsigned PERIOD = 320
) (
    input wire logic clk,
    input wire logic pwm_out,
    input wire logic pwm_enable,
    input wire logic hold,
    input wire logic [11:0] hold_level,
    output logic [11:0] vout_sample
);
    int unsigned cnt = 0;
    int unsigned high = 0;
    logic [11:0] level = 12'(BASE);
    // high time per period; the filter only settles once a period, so
    // the loop sees a lag of up to two averaging windows
    always_ff @(posedge clk) begin
        cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
        high <= (cnt == PERIOD - 1) ? 0 : high + 32'(pwm_enable & pwm_out);
        if (cnt == PERIOD - 1) begin
            level <= 12'(BASE + high);
        end
    end
    // a held level models a broken trim path that ignores the pwm
    assign vout_sample = hold ? hold_level : level;
endmodule : clm_supply_model
`default_nettype wire

// ==== verif/tb_clm_margin_pwm.sv ====
// self-checking bench for the closed-loop margin pwm block
`timescale 1ns/100ps
`default_nettype none
module tb_clm_margin_pwm;
    // --------
    // signals
    // --------
    localparam int unsigned SCYC = 20;
    localparam int unsigned WIN = 8 * SCYC;
    localparam int LIMIT = 40000;
    logic clk;
    logic rst;
    clm_pkg::clm_wreq_t wreq;
    logic [7:0] rd_addr;
    logic clear_faults;
    logic [7:0] operation;
    logic all_power_good;
    logic alert_enable;
    logic [11:0] vout_sample;
    logic [11:0] hi_tgt;
    logic [11:0] lo_tgt;
    logic [15:0] rd_data;
    clm_pkg::clm_status_t status;
    logic pwm_out;
    logic pwm_enable;
    logic [5:0] duty;
    logic alert_n;
    logic hold;
    logic [11:0] hold_level;
    int failures;
    int checks_done;
    int cyc;
    time t0;

    clm_margin_pwm #(.VW(12), .SAMPLE_CYC(SCYC)) dut (
        .clk(clk), .rst(rst), .wreq(wreq), .rd_addr(rd_addr),
        .clear_faults(clear_faults), .operation(operation),
        .all_power_good(all_power_good), .alert_enable(alert_enable),
        .vout_sample(vout_sample), .margin_high_target(hi_tgt),
        .margin_low_target(lo_tgt), .rd_data(rd_data), .status(status),
        .pwm_out(pwm_out), .pwm_enable(pwm_enable), .duty(duty),
        .alert_n(alert_n)
    );

    clm_supply_model #(.PERIOD(clm_pkg::PWM_PERIOD_CYC)) supply (
        .clk(clk), .pwm_out(pwm_out), .pwm_enable(pwm_enable),
        .hold(hold), .hold_level(hold_level), .vout_sample(vout_sample)
    );

    // 50 ns clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // --------
    // tasks
    // --------
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_flag(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : chk_flag

    task automatic ncyc(input int n);
        repeat (n) @(negedge clk);
    endtask : ncyc

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        wreq <= '{wr: 1'b1, addr: a, data: d};
        ncyc(1);
        wreq.wr <= 1'b0;
        ncyc(1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        rd_addr <= a;
        ncyc(1);
        chk_word(rd_data, exp);
    endtask : rd

    // step waits are bounded by one window plus slack
    task automatic wait_duty(input logic [5:0] exp);
        logic [5:0] was;
        int n;
        was = duty;
        n = 0;
        while (duty === was && n < WIN + 8) begin
            ncyc(1);
            n++;
        end
        chk_word({10'h000, duty}, {10'h000, exp});
        chk_flag(n >= WIN - 8, 1'b1);
    endtask : wait_duty

    task automatic wait_fault(input logic exp_alert);
        int n;
        n = 0;
        while (status.status_mfr[0] !== 1'b1 && n < WIN + 8) begin
            ncyc(1);
            n++;
        end
        ncyc(1);
        chk_flag(status.status_byte[clm_pkg::NOTA_BIT], 1'b1);
        chk_flag(status.status_word[clm_pkg::NOTA_BIT], 1'b1);
        chk_flag(status.status_word[clm_pkg::MFR_WORD_BIT], 1'b1);
        chk_flag(status.status_mfr[0], 1'b1);
        chk_flag(alert_n, !exp_alert);
    endtask : wait_fault

    task automatic start(input logic [15:0] setup, input logic [7:0] op);
        wr(clm_pkg::MARGIN_SETUP_WORD_OFS, setup);
        operation <= op;
        ncyc(2);
        chk_flag(pwm_enable, 1'b1);
        chk_word({10'h000, duty}, {10'h000, setup[5:0]});
    endtask : start

    // leave margining first so no new fault races the clear
    task automatic stop(input string name);
        operation <= 8'h00;
        ncyc(2);
        clear_faults <= 1'b1;
        ncyc(1);
        clear_faults <= 1'b0;
        ncyc(2);
        chk_flag(pwm_enable, 1'b0);
        chk_flag(pwm_out, 1'b0);
        chk_flag(alert_n, 1'b1);
        chk_flag(status.status_mfr[0], 1'b0);
        $display("test %s done", name);
    endtask : stop

    task automatic final_report();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    // cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            failures++;
            $display("ERROR %0t: timeout", $time);
            final_report();
        end
    end

    // --------
    // tests
    // --------
    initial begin
        rst = 1'b1;
        wreq = '0;
        rd_addr = 8'h00;
        clear_faults = 1'b0;
        operation = 8'h00;
        all_power_good = 1'b0;
        alert_enable = 1'b1;
        hi_tgt = 12'h7d0;
        lo_tgt = 12'h3e8;
        hold = 1'b1;
        hold_level = 12'h3e8;
        failures = 0;
        checks_done = 0;
        cyc = 0;
        ncyc(6);
        rst = 1'b0;
        ncyc(1);
        rd(8'he0, 16'h0000);
        chk_flag(pwm_enable, 1'b0);
        wr(8'he0, 16'hffff);
        rd(8'he0, 16'h803f);
        wr(8'he1, 16'h0000);
        rd(8'he0, 16'h803f);
        $display("test registers done");
        // gating: not a margin state, then power not good
        wr(8'he0, 16'h803d);
        operation <= 8'hb0; // code 3 in bits 5:4 is not a margin state
        all_power_good <= 1'b1;
        ncyc(4);
        chk_flag(pwm_enable, 1'b0);
        all_power_good <= 1'b0;
        operation <= 8'ha0;
        ncyc(4);
        chk_flag(pwm_enable, 1'b0);
        all_power_good <= 1'b1;
        start(16'h803d, 8'ha0);
        wait_duty(6'h3e);
        wait_duty(6'h3f);
        wait_fault(1'b1);
        rd(8'h78, 16'h0001);
        rd(8'h79, 16'h1001);
        rd(8'h80, 16'h0001);
        ncyc(WIN + 8);
        chk_word({10'h000, duty}, 16'h003f);
        stop("high_to_full");
        // negative slope, alert off
        alert_enable <= 1'b0;
        hold_level <= 12'h5dc;
        start(16'h003e, 8'h90);
        wait_duty(6'h3f);
        wait_fault(1'b0);
        stop("slope_neg");
        alert_enable <= 1'b1;
        start(16'h8001, 8'h90);
        wait_duty(6'h00);
        wait_fault(1'b1);
        stop("low_to_zero");
        // exactly 1% off holds still, one more lsb overshoots the seed
        hold_level <= 12'h7e4;
        start(16'h801e, 8'ha0);
        ncyc(2 * WIN + 8);
        chk_word({10'h000, duty}, 16'h001e);
        chk_flag(status.status_mfr[0], 1'b0);
        stop("band_edge");
        hold_level <= 12'h7e5;
        start(16'h801e, 8'ha0);
        wait_duty(6'h1d);
        wait_fault(1'b1);
        stop("seed_overshoot");
        // closed loop through the trim model
        hold <= 1'b0;
        start(16'h801e, 8'ha0);
        @(posedge pwm_out);
        t0 = $time;
        @(posedge pwm_out);
        chk_word(16'(($time - t0) / 50), 16'(clm_pkg::PWM_PERIOD_CYC));
        ncyc(30 * WIN);
        chk_flag(status.status_mfr[0], 1'b0);
        chk_flag(vout_sample >= 12'h7bc && vout_sample <= 12'h7e4, 1'b1);
        stop("track");
        final_report();
    end
endmodule : tb_clm_margin_pwm
`default_nettype wire
